// ==== verilog/dac_channel_ctrl.sv ====
// Purpose: Channel control logic of a 40-channel converter.
// Assumes: Link pins synchronous to i_core_clk; host keeps its own duties.
// Notes: Serial frames are 32 bits, two 16-bit words, most significant first.
// Contract
// RL1 - Capture serial on falling, launch on rising
// RL2 - Host sends words most significant bit first
// RL3 - Host clocks, frames low, sixteen-bit words
// RL4 - No monitor routing before monitor enable
// RL5 - Channel 39 becomes monitor output in monitor mode
// RL6 - Selected channel routed; address 63 floats output
// RL7 - Special select, address 001100 writes control
// RL8 - Five toggle enables, one per eight channels
// RL9 - Every channel holds A and B registers
// RL10 - B writes only with group toggle enabled
// RL11 - Toggled strobes alternate A then B
// RL12 - Host enables, loads A, loads B, strobes
// RL13 - After disable, next strobe loads A
// RL14 - Thermal shutdown only with guard bit set
// RL15 - Over temperature powers down all amplifiers
// RL16 - Stay down until soft power-up or disable
// RL17 - Write queue only in parallel mode
// RL18 - Queue enable pin sampled only after reset
// RL19 - Parallel writes accepted every 40 ns
// RL20 - Forty queued writes applied within 14.4 us
// RL21 - No toggling during two-wire burst writes
// RL22 - Write strobe rising edge latches address, data
// RL23 - Untoggled groups always load from A
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module dac_channel_ctrl import dac_ctrl_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst,
  dac_link_if.device link,
  input wire logic i_over_temp,
  input wire logic i_burst_mode,
  input wire logic [5:0] i_ch_sel,
  output logic [13:0] o_ch_code,
  output logic [13:0] o_mon_code,
  output logic o_mon_oe,
  output logic o_ch39_monitor,
  output logic o_amp_on,
  output logic o_queue_en
);
  // ==========================================================
  // State.
  logic [8:0] ctrl_r;
  logic [5:0] mon_sel_r;
  logic shutdown_r;
  logic queue_en_r;
  logic init_done_r;
  logic wr_n_q_r;
  logic sclk_q_r;
  logic frame_q_r;
  logic output_load_strobe_q_r;
  logic sdout_r;
  logic [4:0] bitcnt_r;
  logic [30:0] sin_r;
  logic [15:0] sout_r;
  logic [DATA_W-1:0] a_mem [N_CH];
  logic [DATA_W-1:0] b_mem [N_CH];
  logic [DATA_W-1:0] dac_mem [N_CH];
  logic [N_CH-1:0] next_b_r;
  logic [WORD_W-1:0] q_mem [N_CH];
  logic [5:0] q_wr_r;
  logic [5:0] q_rd_r;
  logic [6:0] q_cnt_r;
  logic [4:0] pace_r;

  logic serial_sel;
  logic par_evt;
  logic ser_evt;
  logic output_load_strobe_evt;
  logic sclk_fall;
  logic sclk_rise;
  logic queue_on;
  logic push;
  logic pop;
  logic ap_v;
  logic [WORD_W-1:0] ap_w;
  logic [WORD_W-1:0] par_word;
  logic [WORD_W-1:0] ser_word;
  logic [1:0] ap_reg;
  logic [5:0] ap_addr;
  logic [DATA_W-1:0] ap_data;
  logic ap_is_ch;
  logic soft_pu;
  logic [4:0] tog_grp;
  logic [15:0] status;

  assign serial_sel = link.interface_select_pin;
  assign queue_on = queue_en_r & ~serial_sel; // [RL17]
  // Toggle groups are masked while the two-wire burst is running.
  assign tog_grp = ctrl_r[TOG_MSB:TOG_LSB] & {5{~i_burst_mode}}; // [RL8] [RL21]
  assign status = {shutdown_r, queue_en_r, 5'h00, ctrl_r};

  // ==========================================================
  // Pin edge detection; all pins are already synchronous.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_n_q_r <= 1'b1;
      sclk_q_r <= 1'b1;
      frame_q_r <= 1'b1;
      output_load_strobe_q_r <= 1'b1;
    end else begin
      wr_n_q_r <= link.wr_n;
      sclk_q_r <= link.sclk;
      frame_q_r <= link.frame_n;
      output_load_strobe_q_r <= link.output_load_strobe_n;
    end
  end

  // A low then high write strobe needs two cycles, which is the 40 ns pace.
  assign par_evt = ~serial_sel & ~link.cs_n & ~wr_n_q_r & link.wr_n; // [RL22] [RL19]
  assign par_word = {link.target_register_select, link.channel_address_bus, link.data_bus};
  assign output_load_strobe_evt = output_load_strobe_q_r & ~link.output_load_strobe_n;
  assign sclk_fall = serial_sel & ~link.frame_n & sclk_q_r & ~link.sclk;
  assign sclk_rise = serial_sel & ~link.frame_n & ~sclk_q_r & link.sclk;
  assign ser_evt = sclk_fall & (bitcnt_r == 5'h1F);
  assign ser_word = {sin_r[30:29], sin_r[28:23], sin_r[12:0], link.sdin};

  // ==========================================================
  // Serial receive: bits shift in on the falling clock edge.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bitcnt_r <= 5'h00;
      sin_r <= '0;
    end else if (link.frame_n) begin
      bitcnt_r <= 5'h00;
    end else if (sclk_fall) begin
      sin_r <= {sin_r[29:0], link.sdin}; // [RL1]
      bitcnt_r <= bitcnt_r + 5'h01;
    end
  end

  // Serial readback: status loads at frame start, shifts on rising edges.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sout_r <= '0;
      sdout_r <= 1'b0;
    end else if (frame_q_r & ~link.frame_n) begin
      sout_r <= status;
      sdout_r <= status[15];
    end else if (sclk_rise) begin
      sout_r <= {sout_r[14:0], 1'b0};
      sdout_r <= sout_r[14]; // [RL1]
    end
  end
  assign link.sdout = sdout_r;

  // ==========================================================
  // Queue mode is caught once after reset; later pin changes are ignored.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      init_done_r <= 1'b0;
      queue_en_r <= 1'b0;
    end else if (!init_done_r) begin
      init_done_r <= 1'b1;
      queue_en_r <= link.write_queue_enable_pin & ~serial_sel; // [RL18]
    end
  end

  // ==========================================================
  // Write queue; a write into a full queue is dropped.
  assign push = par_evt & queue_on & (q_cnt_r != 7'(N_CH));
  assign pop = queue_on & (q_cnt_r != 7'h00) & (pace_r == APPLY_LAST); // [RL20]

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      q_wr_r <= 6'h00;
      q_rd_r <= 6'h00;
      q_cnt_r <= 7'h00;
      pace_r <= 5'h00;
    end else begin
      if (push) begin
        q_wr_r <= (q_wr_r == LAST_CH) ? 6'h00 : q_wr_r + 6'h01;
      end
      if (pop) begin
        q_rd_r <= (q_rd_r == LAST_CH) ? 6'h00 : q_rd_r + 6'h01;
      end
      q_cnt_r <= q_cnt_r + 7'(push) - 7'(pop);
      // Pacing runs only while entries wait, so a fresh queue waits a full 18 cycles before its first write.
      pace_r <= (pop || q_cnt_r == 7'h00) ? 5'h00 : pace_r + 5'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      q_mem[q_wr_r] <= par_word;
    end
  end

  // ==========================================================
  // One write source per cycle, chosen by interface mode.
  always_comb begin
    if (serial_sel) begin
      ap_v = ser_evt;
      ap_w = ser_word;
    end else if (queue_on) begin
      ap_v = pop;
      ap_w = q_mem[q_rd_r];
    end else begin
      ap_v = par_evt;
      ap_w = par_word;
    end
  end
  assign ap_reg = ap_w[21:20];
  assign ap_addr = ap_w[19:14];
  assign ap_data = ap_w[13:0];
  assign ap_is_ch = ap_addr <= LAST_CH;
  assign soft_pu = ap_v & (ap_reg == SEL_SPECIAL) & (ap_addr == SOFT_PU_ADDR);

  // ==========================================================
  // Special function writes.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= CTRL_RST;
      mon_sel_r <= MON_HIZ_CH;
    end else if (ap_v && ap_reg == SEL_SPECIAL) begin
      if (ap_addr == CTRL_ADDR) begin
        ctrl_r <= ap_data[8:0]; // [RL7]
      end
      if (ap_addr == MON_SEL_ADDR) begin
        mon_sel_r <= ap_data[5:0]; // [RL6]
      end
    end
  end

  // Channel input registers; B is refused unless its group toggles.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < N_CH; i++) begin
        a_mem[i] <= '0;
        b_mem[i] <= '0;
      end
    end else if (ap_v && ap_is_ch) begin
      if (ap_reg == SEL_A_DATA) begin
        a_mem[ap_addr] <= ap_data; // [RL9]
      end
      if (ap_reg == SEL_B_DATA && tog_grp[ap_addr[5:3]]) begin
        b_mem[ap_addr] <= ap_data; // [RL10]
      end
    end
  end

  // ==========================================================
  // Load strobe: toggled channels alternate, others always take A.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      next_b_r <= '0;
      for (int i = 0; i < N_CH; i++) begin
        dac_mem[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_CH; i++) begin
        if (!tog_grp[i / 8]) begin
          next_b_r[i] <= 1'b0; // [RL13]
          if (output_load_strobe_evt) begin
            dac_mem[i] <= a_mem[i]; // [RL23] [RL13]
          end
        end else if (output_load_strobe_evt) begin
          dac_mem[i] <= next_b_r[i] ? b_mem[i] : a_mem[i]; // [RL11]
          next_b_r[i] <= ~next_b_r[i];
        end
      end
    end
  end

  // ==========================================================
  // Thermal guard; a fresh over-temperature beats a soft power-up.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      shutdown_r <= 1'b0;
    end else if (!ctrl_r[THERM_BIT]) begin
      shutdown_r <= 1'b0; // [RL14] [RL16]
    end else if (i_over_temp) begin
      shutdown_r <= 1'b1; // [RL15]
    end else if (soft_pu) begin
      shutdown_r <= 1'b0; // [RL16]
    end
  end

  // ==========================================================
  // Registered user outputs.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ch_code <= '0;
      o_mon_code <= '0;
      o_mon_oe <= 1'b0;
      o_ch39_monitor <= 1'b0;
      o_amp_on <= 1'b1;
      o_queue_en <= 1'b0;
    end else begin
      o_amp_on <= ~shutdown_r;
      o_queue_en <= queue_on;
      o_ch39_monitor <= ctrl_r[MON_EN_BIT]; // [RL5]
      if (i_ch_sel > LAST_CH || (ctrl_r[MON_EN_BIT] && i_ch_sel == LAST_CH)) begin
        o_ch_code <= '0; // [RL5]
      end else begin
        o_ch_code <= dac_mem[i_ch_sel];
      end
      // Unused addresses above the last channel float the output like 63.
      if (ctrl_r[MON_EN_BIT] && mon_sel_r != MON_HIZ_CH && mon_sel_r <= LAST_CH) begin
        o_mon_oe <= 1'b1; // [RL4] [RL6]
        o_mon_code <= dac_mem[mon_sel_r];
      end else begin
        o_mon_oe <= 1'b0;
        o_mon_code <= '0;
      end
    end
  end
endmodule

// ==== verilog/dac_ctrl_pkg.sv ====
// Purpose: Shared constants for the converter channel control ends.
// Assumes: One 50 MHz core clock on both ends.
// Notes: Word fields are {target_register_select, channel address, data}.
package dac_ctrl_pkg;
  // ==========================================================
  // Sizes and clock.
  localparam int N_CH = 40;
  localparam int DATA_W = 14;
  localparam int ADDR_W = 6;
  localparam int WORD_W = 22;
  localparam int SER_BITS = 32;
  localparam int CLK_MHZ = 50;
  // ==========================================================
  // Write decode.
  localparam logic [1:0] SEL_SPECIAL = 2'h0;
  localparam logic [1:0] SEL_B_DATA = 2'h2;
  localparam logic [1:0] SEL_A_DATA = 2'h3;
  localparam logic [5:0] CTRL_ADDR = 6'h0C;
  localparam logic [5:0] MON_SEL_ADDR = 6'h0D;
  localparam logic [5:0] SOFT_PU_ADDR = 6'h09;
  localparam logic [5:0] MON_HIZ_CH = 6'h3F;
  localparam logic [5:0] LAST_CH = 6'h27;
  // ==========================================================
  // Control register fields and reset value.
  localparam int MON_EN_BIT = 0;
  localparam int TOG_LSB = 2;
  localparam int TOG_MSB = 6;
  localparam int THERM_BIT = 8;
  localparam logic [8:0] CTRL_RST = 9'h000;
  // ==========================================================
  // Timing.
  localparam int WRITE_CYCLE_NS = 40;
  localparam int WRITE_CYC = (WRITE_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int GROUP_UPDATE_NS = 14400;
  localparam int APPLY_CYC = GROUP_UPDATE_NS * CLK_MHZ / 1000 / N_CH;
  localparam logic [4:0] APPLY_LAST = 5'(APPLY_CYC - 1);
  localparam logic [1:0] SCLK_HALF_LAST = 2'h1;
  // ==========================================================
  // Host register offsets (AHB-Lite byte addresses).
  localparam logic [7:0] HOST_CFG_OFS = 8'h00;
  localparam logic [7:0] HOST_CMD_OFS = 8'h04;
  localparam logic [7:0] HOST_STROBE_OFS = 8'h08;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h0C;
  localparam logic [1:0] CFG_RST = 2'h0;
endpackage

// ==== verilog/dac_link_if.sv ====
// Purpose: Pins between the converter control logic and its host.
// Assumes: All pins are synchronous to the shared core clock.
// Notes: Active low pins carry the _n suffix.
`timescale 1ns/100ps
interface dac_link_if;
  // ==========================================================
  // Parallel port, strobe and straps.
  logic cs_n;
  logic wr_n;
  logic [1:0] target_register_select;
  logic [5:0] channel_address_bus;
  logic [13:0] data_bus;
  logic output_load_strobe_n;
  logic interface_select_pin;
  logic write_queue_enable_pin;
  // ==========================================================
  // Framed serial port.
  logic sclk;
  logic frame_n;
  logic sdin;
  logic sdout;

  modport device (
    input cs_n, wr_n, target_register_select, channel_address_bus, data_bus,
    input output_load_strobe_n, interface_select_pin, write_queue_enable_pin,
    input sclk, frame_n, sdin,
    output sdout
  );
  modport host (
    output cs_n, wr_n, target_register_select, channel_address_bus, data_bus,
    output output_load_strobe_n, interface_select_pin, write_queue_enable_pin,
    output sclk, frame_n, sdin,
    input sdout
  );
endinterface

// ==== verilog/dac_host_ctrl.sv ====
// Purpose: Host end that drives the converter link from AHB-Lite registers.
// Assumes: Zero wait state slave; one transfer on the link at a time.
// Notes: Commands written while busy are dropped; poll status first.
`timescale 1ns/100ps
module dac_host_ctrl import dac_ctrl_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  dac_link_if.host link
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_PAR = 2'b01,
    H_SER_HI = 2'b10,
    H_SER_LO = 2'b11
  } host_state_e;

  // ==========================================================
  // State.
  host_state_e state_r;
  logic wr_pend_r;
  logic [7:0] wr_ofs_r;
  logic [1:0] cfg_r;
  logic [31:0] sh_r;
  logic [4:0] bit_r;
  logic [1:0] tim_r;
  logic [15:0] rb_r;
  logic cs_n_r;
  logic wr_n_r;
  logic output_load_strobe_n_r;
  logic sclk_r;
  logic frame_n_r;
  logic sdin_r;
  logic [21:0] word_r;
  logic cmd_go;
  logic strobe_go;
  logic busy;

  assign busy = state_r != H_IDLE;
  assign cmd_go = wr_pend_r & (wr_ofs_r == HOST_CMD_OFS) & ~busy;
  assign strobe_go = wr_pend_r & (wr_ofs_r == HOST_STROBE_OFS);

  // ==========================================================
  // AHB-Lite slave: reads answer in the data phase, writes land there.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
      o_hrdata <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      wr_pend_r <= i_hsel & i_htrans[1] & i_hready & i_hwrite;
      wr_ofs_r <= i_haddr[7:0];
      if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
        unique case (i_haddr[7:0])
          HOST_CFG_OFS: o_hrdata <= {30'h0, cfg_r};
          HOST_STATUS_OFS: o_hrdata <= {rb_r, 15'h0000, busy};
          default: o_hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r <= CFG_RST;
    end else if (wr_pend_r && wr_ofs_r == HOST_CFG_OFS) begin
      cfg_r <= i_hwdata[1:0];
    end
  end

  // A one-cycle low pulse is enough; the device reacts to the falling edge.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      output_load_strobe_n_r <= 1'b1;
    end else begin
      output_load_strobe_n_r <= ~(strobe_go & ~busy); // [RL12]
    end
  end

  // ==========================================================
  // Link sequencer for parallel and framed serial writes.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= H_IDLE;
      cs_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      word_r <= '0;
      sclk_r <= 1'b1;
      frame_n_r <= 1'b1;
      sdin_r <= 1'b0;
      sh_r <= '0;
      bit_r <= 5'h00;
      tim_r <= 2'h0;
      rb_r <= 16'h0000;
    end else begin
      unique case (state_r)
        H_IDLE: begin
          cs_n_r <= 1'b1;
          wr_n_r <= 1'b1;
          if (cmd_go && !cfg_r[0]) begin
            word_r <= {i_hwdata[23:22], i_hwdata[21:16], i_hwdata[13:0]};
            cs_n_r <= 1'b0;
            wr_n_r <= 1'b0;
            state_r <= H_PAR;
          end else if (cmd_go) begin
            // First 16-bit word holds select and address, second the data.
            sh_r <= {i_hwdata[23:16], 8'h00, 2'b00, i_hwdata[13:0]}; // [RL3]
            sdin_r <= i_hwdata[23]; // [RL2]
            frame_n_r <= 1'b0; // [RL3]
            bit_r <= 5'h00;
            tim_r <= 2'h0;
            state_r <= H_SER_HI;
          end
        end
        H_PAR: begin
          wr_n_r <= 1'b1; // [RL22] [RL19]
          state_r <= H_IDLE;
        end
        H_SER_HI: begin
          tim_r <= tim_r + 2'h1;
          if (tim_r == SCLK_HALF_LAST) begin
            sclk_r <= 1'b0;
            tim_r <= 2'h0;
            if (bit_r < 5'h10) begin
              rb_r <= {rb_r[14:0], link.sdout};
            end
            state_r <= H_SER_LO;
          end
        end
        H_SER_LO: begin
          tim_r <= tim_r + 2'h1;
          if (tim_r == SCLK_HALF_LAST) begin
            tim_r <= 2'h0;
            sclk_r <= 1'b1;
            if (bit_r == 5'h1F) begin
              frame_n_r <= 1'b1;
              state_r <= H_IDLE;
            end else begin
              sh_r <= {sh_r[30:0], 1'b0};
              sdin_r <= sh_r[30]; // [RL2]
              bit_r <= bit_r + 5'h01;
              state_r <= H_SER_HI;
            end
          end
        end
      endcase
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.wr_n = wr_n_r;
  assign link.target_register_select = word_r[21:20];
  assign link.channel_address_bus = word_r[19:14];
  assign link.data_bus = word_r[13:0];
  assign link.output_load_strobe_n = output_load_strobe_n_r;
  assign link.interface_select_pin = cfg_r[0];
  assign link.write_queue_enable_pin = cfg_r[1];
  assign link.sclk = sclk_r;
  assign link.frame_n = frame_n_r;
  assign link.sdin = sdin_r;
endmodule

// ==== dv/dac_ctrl_sva.sv ====
// Purpose: Link and status checks for the converter control pair.
// Assumes: One core clock; reset is active high.
// Notes: Watches the link pins and the device status outputs.
`timescale 1ns/100ps
module dac_ctrl_sva (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic sdin,
  input wire logic sdout,
  input wire logic interface_select_pin,
  input wire logic i_over_temp,
  input wire logic o_amp_on,
  input wire logic o_mon_oe,
  input wire logic o_ch39_monitor,
  input wire logic o_queue_en
);
  // ==========================================================
  // All checks share the core clock and sleep during reset.
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  AST_WR_PULSE: assert property ($fell(wr_n) |=> wr_n[*2])
    else $error("write strobes too close");
  AST_WR_SEL: assert property (!wr_n |-> !cs_n)
    else $error("write strobe without select");
  AST_SCLK_IDLE: assert property (frame_n |-> sclk)
    else $error("serial clock not idle high");
  AST_SDIN_HOLD: assert property (!frame_n && $changed(sdin) |-> $rose(sclk) || $fell(frame_n))
    else $error("serial input moved off the rising clock");
  // Launch on rising clock: a change must follow a high clock sample.
  AST_SDOUT_LAUNCH: assert property (!frame_n && !$past(frame_n) && $changed(sdout)
    |-> $past(sclk))
    else $error("serial output moved after a low clock");
  AST_THERM_DOWN: assert property ($fell(o_amp_on)
    |-> $past(i_over_temp) || $past(i_over_temp, 2))
    else $error("amplifiers off without over temperature");
  AST_THERM_HOLD: assert property (!o_amp_on && i_over_temp |=> !o_amp_on)
    else $error("amplifiers back on while hot");
  AST_MON_OFF: assert property (!o_ch39_monitor && !$past(o_ch39_monitor) |-> !o_mon_oe)
    else $error("monitor driven while disabled");
  AST_QUEUE_SER: assert property (interface_select_pin |=> !o_queue_en)
    else $error("queue active in serial mode");
  AST_QUEUE_STRAP: assert property ($rose(o_queue_en) |-> $past(i_rst, 2) || $past(i_rst, 3)
    || $past(interface_select_pin) || $past(interface_select_pin, 2))
    else $error("queue enabled outside reset");
endmodule

// ==== dv/multichannel_dac_control_logic_bench.sv ====
// Purpose: Self-checking bench for the host and channel control ends.
// Assumes: Zero wait AHB-Lite slave; model of channels kept in arrays.
// Notes: The device has a reset of its own so the queue strap can be caught mid-run.
`timescale 1ns/100ps
module multichannel_dac_control_logic_bench import dac_ctrl_pkg::*;;
  logic clk, rst, dev_rst, hsel, hwrite, hready, hresp, over_temp, burst;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [5:0] ch_sel;
  logic [13:0] ch_code, mon_code;
  logic mon_oe, ch39_mon, amp_on, queue_en;
  int fails, total_checks, cyc, ctrl_m, msel_m, r;
  int a_m[41], b_m[41], o_m[41];
  bit ph[41];
  dac_link_if link();
  dac_channel_ctrl dac_channel_ctrl_i (.i_core_clk(clk), .i_rst(dev_rst), .link(link),
    .i_over_temp(over_temp), .i_burst_mode(burst), .i_ch_sel(ch_sel), .o_ch_code(ch_code),
    .o_mon_code(mon_code), .o_mon_oe(mon_oe), .o_ch39_monitor(ch39_mon),
    .o_amp_on(amp_on), .o_queue_en(queue_en));
  dac_host_ctrl dac_host_ctrl_i (.i_core_clk(clk), .i_rst(rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata),
    .o_hresp(hresp), .link(link));
  dac_ctrl_sva dac_ctrl_sva_i (.i_core_clk(clk), .i_rst(dev_rst), .cs_n(link.cs_n),
    .wr_n(link.wr_n), .sclk(link.sclk), .frame_n(link.frame_n), .sdin(link.sdin),
    .sdout(link.sdout), .interface_select_pin(link.interface_select_pin),
    .i_over_temp(over_temp), .o_amp_on(amp_on), .o_mon_oe(mon_oe),
    .o_ch39_monitor(ch39_mon), .o_queue_en(queue_en));
  // ==========================================================
  // Clock and hang guard; the ceiling is far above the planned run.
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      fails++;
      print_verdict();
    end
  end
  // ==========================================================
  // Helpers.
  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // One single transfer; the master waits for hready in both phases.
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task w4();
    repeat (4) @(posedge clk);
  endtask
  function bit tg(int c);
    return ctrl_m[2 + c / 8] && !burst;
  endfunction
  // A group that is off, or masked by burst, restarts its phase at A.
  function void fix_ph();
    for (int c = 0; c < 40; c++) if (!tg(c)) ph[c] = 0;
  endfunction
  task wr(input int s, input int c, input int d);
    d = d & 32'h3fff;
    ahb(1, HOST_CMD_OFS, {8'h0, s[1:0], c[5:0], 2'h0, d[13:0]});
    do ahb(0, HOST_STATUS_OFS, 0); while (rd[0] !== 1'b0);
    if (s == 3) a_m[c] = d;
    if (s == 2 && tg(c)) b_m[c] = d;
    if (s == 0 && c == 12) ctrl_m = d & 32'h17d;
    if (s == 0 && c == 13) msel_m = d & 63;
    fix_ph();
  endtask
  task strobe();
    ahb(1, HOST_STROBE_OFS, 0);
    w4();
    for (int c = 0; c < 40; c++) begin
      o_m[c] = (tg(c) && ph[c]) ? b_m[c] : a_m[c];
      ph[c] = tg(c) && !ph[c];
    end
  endtask
  task chk_all();
    for (int c = 0; c <= 40; c++) begin
      ch_sel <= c[5:0];
      repeat (2) @(posedge clk);
      chk(ch_code, (c == 39 && ctrl_m[0]) ? 0 : o_m[c]);
    end
  endtask
  task load_all();
    for (int c = 0; c < 40; c++) begin
      wr(3, c, $urandom);
      wr(2, c, $urandom);
    end
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    rst = 1;
    dev_rst = 1;
    hsel = 0;
    htrans = 0;
    hwrite = 0;
    haddr = 0;
    hwdata = 0;
    over_temp = 0;
    burst = 0;
    ch_sel = 0;
    msel_m = 63;
    void'($urandom(32'heeee));
    repeat (6) @(posedge clk);
    rst <= 0;
    dev_rst <= 0;
    // Parallel loads; B writes must be dropped while toggling is off.
    load_all();
    strobe();
    chk_all();
    chk(hresp, 0);
    $display("test 1 done");
    // Random groups, then all groups; three strobes give A, B, A, or B, A, B for groups still on from the first pass.
    for (int k = 0; k < 2; k++) begin
      wr(0, 12, k ? 32'h7c : $urandom & 32'h7c);
      load_all();
      repeat (3) begin
        strobe();
        chk_all();
      end
    end
    $display("test 2 done");
    // Burst masks toggling; after disable the next strobe gives A.
    burst <= 1;
    @(posedge clk);
    fix_ph();
    strobe();
    chk_all();
    burst <= 0;
    @(posedge clk);
    strobe();
    wr(0, 12, 0);
    strobe();
    chk_all();
    $display("test 3 done");
    // Monitor routing.
    wr(0, 13, 5);
    w4();
    chk(mon_oe, 0);
    r = $urandom % 40;
    wr(0, 12, 1);
    wr(0, 13, r);
    w4();
    chk(mon_oe, 1);
    chk(mon_code, o_m[r]);
    chk(ch39_mon, 1);
    chk_all();
    wr(0, 13, 63);
    w4();
    chk(mon_oe, 0);
    chk(mon_code, 0);
    wr(0, 12, 0);
    $display("test 4 done");
    // Thermal guard.
    over_temp <= 1;
    w4();
    chk(amp_on, 1);
    wr(0, 12, 256);
    w4();
    chk(amp_on, 0);
    wr(0, 9, 0);
    over_temp <= 0;
    w4();
    chk(amp_on, 0);
    wr(0, 9, 0);
    w4();
    chk(amp_on, 1);
    over_temp <= 1;
    w4();
    over_temp <= 0;
    chk(amp_on, 0);
    wr(0, 12, 0);
    w4();
    chk(amp_on, 1);
    $display("test 5 done");
    // Serial frames: writes land and status reads back the control word.
    ahb(1, HOST_CFG_OFS, 1);
    w4();
    chk(queue_en, 0);
    wr(0, 12, 4);
    wr(3, 3, $urandom);
    wr(2, 3, $urandom);
    chk(rd[31:16], ctrl_m & 32'h1ff);
    strobe();
    strobe();
    chk_all();
    $display("test 6 done");
    // The host reset clears the strap, so only the device is reset to catch it.
    ahb(1, HOST_CFG_OFS, 2);
    dev_rst <= 1;
    w4();
    dev_rst <= 0;
    ctrl_m = 0;
    msel_m = 63;
    for (int c = 0; c < 41; c++) begin
      a_m[c] = 0;
      b_m[c] = 0;
      o_m[c] = 0;
      ph[c] = 0;
    end
    w4();
    chk(queue_en, 1);
    for (int c = 0; c < 40; c++) wr(3, c, $urandom);
    repeat (720) @(posedge clk);
    strobe();
    chk_all();
    ahb(1, HOST_CFG_OFS, 0);
    w4();
    chk(queue_en, 1);
    ahb(1, HOST_CFG_OFS, 1);
    w4();
    chk(queue_en, 0);
    $display("test 7 done");
    print_verdict();
  end
endmodule
